// [hdl/aoc_top.sv]
// module: adc output conditioning datapath
`timescale 1ns/1ns
module aoc_top (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire aoc_pkg::aoc_cfg_t cfg,
  input  wire aoc_pkg::aoc_smp_t raw_in,
  output aoc_pkg::aoc_smp_t     dout,
  output aoc_pkg::aoc_pwr_t     pwr,
  output logic [1:0]            ovf,
  output logic                  mod_strobe
);
  import aoc_pkg::*;

  typedef struct packed {
    logic [AW-1:0] est_l;
    logic [AW-1:0] est_r;
    aoc_smp_t      out;
    logic [1:0]    ovf;
    aoc_pwr_t      pwr;
    logic [5:0]    mcnt;
    logic          mstb;
  } aoc_state_t;

  aoc_state_t s_q, s_d;

  function automatic logic [DW-1:0] sat(input logic signed [DW+1:0] v);
    if (v > $signed({2'b00, MAX_CODE})) sat = MAX_CODE;
    else if (v < $signed({2'b11, MIN_CODE})) sat = MIN_CODE;
    else sat = v[DW-1:0];
  endfunction

  function automatic logic clip(input logic signed [DW+1:0] v);
    clip = (v > $signed({2'b00, MAX_CODE})) || (v < $signed({2'b11, MIN_CODE}));
  endfunction

  function automatic logic [DW-1:0] pick(input logic [1:0] sel, input logic [DW-1:0] l,
                                         input logic [DW-1:0] r);
    logic signed [DW:0] m;
    m = ($signed({l[DW-1], l}) + $signed({r[DW-1], r})) >>> 1;
    case (sel)
      SWAP_LEFT:  pick = l;
      SWAP_RIGHT: pick = r;
      SWAP_MONO:  pick = m[DW-1:0];
      default:    pick = l;
    endcase
  endfunction

  logic signed [DW+1:0] hp [2];
  logic signed [DW+1:0] fin [2];
  logic [DW-1:0]        ch [2];
  logic [DW-1:0]        conv [2];
  logic [DW-1:0]        eng [2];
  logic signed [DW+1:0] mixd;
  logic signed [DW+8:0] vol [2];

  always_comb begin
    logic [AW-1:0] est [2];
    logic signed [DW:0] dif;
    s_d = s_q;
    est[0] = s_q.est_l;
    est[1] = s_q.est_r;
    dif = $signed({raw_in.left[DW-1], raw_in.left}) - $signed({raw_in.right[DW-1], raw_in.right});
    mixd = $signed({dif[DW], dif}) >>> 1;
    for (int i = 0; i < 2; i++) begin
      conv[i] = cfg.diff_mix ? sat(mixd) : (i == 0 ? raw_in.left : raw_in.right);
      if (cfg.filt_en[i])
        hp[i] = $signed({{2{conv[i][DW-1]}}, conv[i]}) -
                $signed({{2{est[i][AW-1]}}, est[i][AW-1:AW-DW]});
      else
        hp[i] = $signed({{2{conv[i][DW-1]}}, conv[i]});
      ch[i] = sat(hp[i]);
    end
    for (int i = 0; i < 2; i++) begin
      eng[i] = pick(i == 0 ? cfg.left_swap : cfg.right_swap, ch[0], ch[1]);
      vol[i] = ($signed({{9{eng[i][DW-1]}}, eng[i]}) * $signed({1'b0, 8'h80 - {1'b0, cfg.mix_vol}}))
               >>> 7;
      fin[i] = (cfg.proc_sel ? vol[i][DW+1:0] : $signed({{2{ch[i][DW-1]}}, ch[i]}))
               + $signed({2'b00, ANTI_TOGGLE_OFS});
    end
    if (raw_in.valid) begin
      for (int i = 0; i < 2; i++) begin
        if (cfg.filt_en[i] && !cfg.filt_frz[i])
          est[i] = est[i] + AW'(($signed({conv[i][DW-1], conv[i], 4'h0}) -
                   $signed({est[i][AW-1], est[i]})) >>> HPF_SHIFT);
      end
      s_d.out.left  = sat(fin[0]);
      s_d.out.right = sat(fin[1]);
      s_d.ovf = {clip(fin[1]) | clip(hp[1]), clip(fin[0]) | clip(hp[0])};
    end
    s_d.est_l = est[0];
    s_d.est_r = est[1];
    s_d.out.valid = raw_in.valid;
    s_d.mcnt = (s_q.mcnt == 6'(OSR - 1)) ? 6'h00 : s_q.mcnt + 6'h01;
    s_d.mstb = (s_q.mcnt == 6'(OSR - 1));
    if (cfg.hw_mode) begin
      s_d.pwr.core_on = 1'b1;
      s_d.pwr.adc_on  = 2'b11;
      s_d.pwr.pga_on  = 2'b11;
      s_d.pwr.pre_on  = 2'b00;
      s_d.pwr.bias_on = 1'b0;
      s_d.pwr.speed   = cfg.master ? SPD_SINGLE : cfg.speed_det;
    end else begin
      s_d.pwr.core_on = !cfg.pdn_dev;
      s_d.pwr.adc_on  = ~cfg.pdn_adc;
      s_d.pwr.pga_on  = ~cfg.pdn_pga;
      s_d.pwr.pre_on  = ~cfg.pdn_pre;
      s_d.pwr.bias_on = !cfg.pdn_bias;
      s_d.pwr.speed   = (cfg.auto_detect && !cfg.master) ? cfg.speed_det : cfg.speed_sw;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
  assign ovf = s_q.ovf;
  assign pwr = s_q.pwr;
  assign mod_strobe = s_q.mstb;

  ////////////////////////////////////////////////////////////////////////
  sequence frz_seq;
    raw_in.valid && cfg.filt_frz[0];
  endsequence

  frozen_est_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frz_seq |=> s_q.est_l == $past(s_q.est_l))
    else $error("frozen estimate moved");
  bypass_est_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (raw_in.valid && !cfg.filt_en[1]) |=> s_q.est_r == $past(s_q.est_r))
    else $error("disabled filter estimate moved");
  strobe_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mod_strobe |=> !mod_strobe [*8])
    else $error("modulator strobe too frequent");
  strobe_cnt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mod_strobe |-> ##64 mod_strobe)
    else $error("modulator strobe period wrong");
  clip_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (raw_in.valid && raw_in.left == MAX_CODE && !cfg.diff_mix && !cfg.filt_en[0] && !cfg.proc_sel)
    |=> ovf[0] && dout.left == MAX_CODE)
    else $error("full scale input not clipped");
  hw_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.hw_mode |=> pwr.core_on && pwr.adc_on == 2'b11 && pwr.pre_on == 2'b00 && !pwr.bias_on)
    else $error("strapped power defaults wrong");
  hw_speed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg.hw_mode && cfg.master) |=> pwr.speed == SPD_SINGLE)
    else $error("strapped master not single speed");
  sw_pdn_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.hw_mode |=> pwr.pga_on == ~$past(cfg.pdn_pga) && pwr.bias_on == !$past(cfg.pdn_bias))
    else $error("power-down control not applied");
endmodule

// [hdl/aoc_pkg.sv]
// package: constants and carrier types for the adc output conditioning block
package aoc_pkg;
  localparam int DW = 24;
  localparam int AW = 28;
  localparam logic [DW-1:0] MAX_CODE = 24'h7FFFFF;
  localparam logic [DW-1:0] MIN_CODE = 24'h800000;
  localparam logic [DW-1:0] ANTI_TOGGLE_OFS = 24'h000160;
  localparam int HPF_SHIFT = 10;
  localparam int OSR = 64;
  localparam logic [6:0] MIX_VOL_RST = 7'h00;
  localparam logic [1:0] SWAP_LEFT = 2'h0;
  localparam logic [1:0] SWAP_RIGHT = 2'h3;
  localparam logic [1:0] SWAP_MONO = 2'h1;

  typedef enum logic [1:0] {SPD_QUARTER, SPD_HALF, SPD_SINGLE, SPD_DOUBLE} aoc_speed_t;

  typedef struct packed {
    logic       hw_mode;
    logic       master;
    logic       auto_detect;
    aoc_speed_t speed_sw;
    aoc_speed_t speed_det;
    logic [1:0] filt_en;
    logic [1:0] filt_frz;
    logic       proc_sel;
    logic       diff_mix;
    logic [6:0] mix_vol;
    logic [1:0] left_swap;
    logic [1:0] right_swap;
    logic       pdn_dev;
    logic [1:0] pdn_adc;
    logic [1:0] pdn_pga;
    logic [1:0] pdn_pre;
    logic       pdn_bias;
  } aoc_cfg_t;

  typedef struct packed {
    logic          valid;
    logic [DW-1:0] left;
    logic [DW-1:0] right;
  } aoc_smp_t;

  typedef struct packed {
    logic       core_on;
    logic [1:0] adc_on;
    logic [1:0] pga_on;
    logic [1:0] pre_on;
    logic       bias_on;
    aoc_speed_t speed;
  } aoc_pwr_t;
endpackage

// [test/aoc_host_model.sv]
// host model: collects the conditioned sample words
`timescale 1ns/1ns
module aoc_host_model (
  input  wire logic              clk_sys,
  input  wire aoc_pkg::aoc_smp_t dout,
  output aoc_pkg::aoc_smp_t      last,
  output int                     n_rx
);
  import aoc_pkg::*;
  int cnt = 0;
  assign n_rx = cnt;
  always @(posedge clk_sys) begin
    if (dout.valid === 1'b1) begin
      last <= dout;
      cnt <= cnt + 1;
    end
  end
endmodule

// [test/aoc_top_bench.sv]
// bench: conditioning datapath driven sample by sample
`timescale 1ns/1ns
module aoc_top_bench;
  import aoc_pkg::*;
  logic          clk_sys = 0;
  logic          rst_n = 0;
  aoc_cfg_t      cfg = '0;
  aoc_smp_t      raw_in = '0;
  aoc_smp_t      dout;
  aoc_smp_t      last;
  aoc_pwr_t      pwr;
  logic [1:0]    ovf;
  logic          mod_strobe;
  int            n_rx;
  int            num_errors = 0;
  int            n_checks = 0;
  int            cyc = 0;
  int            n_strobe = 0;
  logic [DW-1:0] held;
  aoc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .raw_in(raw_in), .dout(dout),
    .pwr(pwr), .ovf(ovf), .mod_strobe(mod_strobe));
  aoc_host_model u_host (.clk_sys(clk_sys), .dout(dout), .last(last), .n_rx(n_rx));
  always #50 clk_sys = ~clk_sys;
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [DW-1:0] l, input logic [DW-1:0] r);
    int n0;
    n0 = n_rx;
    @(posedge clk_sys);
    raw_in <= '{1'b1, l, r};
    @(posedge clk_sys);
    raw_in.valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(DW'(n_rx - n0), 24'h1, "sample count");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    send(24'h001000, 24'hFFF000);
    chk(last.left, 24'h001160, "dc left");
    chk(last.right, 24'hFFF160, "dc right");
    send(24'h7FFFFF, 24'h000000);
    chk(last.left, MAX_CODE, "clip");
    chk(DW'(ovf), 24'h1, "ovf set");
    cfg.diff_mix <= 1'b1;
    send(24'h000400, 24'h000200);
    chk(last.left, 24'h000260, "diff");
    chk(DW'(ovf), 24'h0, "ovf clear");
    send(24'h000200, 24'h000400);
    chk(last.left, 24'h000060, "diff neg");
    chk(last.right, 24'h000060, "diff neg right");
    cfg.diff_mix <= 1'b0;
    cfg.proc_sel <= 1'b1;
    cfg.left_swap <= SWAP_RIGHT;
    cfg.right_swap <= SWAP_MONO;
    cfg.mix_vol <= 7'h40;
    send(24'h001000, 24'h002000);
    chk(last.left, 24'h001160, "swap left");
    chk(last.right, 24'h000D60, "mono right");
    cfg.proc_sel <= 1'b0;
    cfg.filt_en <= 2'h3;
    send(24'h004000, 24'h004000);
    chk(last.left, 24'h004160, "hpf start");
    repeat (40) send(24'h004000, 24'h004000);
    chk(DW'(last.left < 24'h004160), 24'h1, "hpf tracks");
    cfg.filt_frz <= 2'h3;
    send(24'h004000, 24'h004000);
    held = last.left;
    send(24'h004000, 24'h004000);
    chk(last.left, held, "frozen");
    repeat (640) begin
      @(posedge clk_sys);
      #1;
      if (mod_strobe === 1'b1) n_strobe++;
    end
    chk(DW'(n_strobe), 24'hA, "strobes");
    cfg.hw_mode <= 1'b1;
    cfg.speed_det <= SPD_HALF;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(DW'(pwr), DW'({1'b1, 2'h3, 2'h3, 2'h0, 1'b0, SPD_HALF}), "hw slave");
    cfg.master <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(DW'(pwr.speed), DW'(SPD_SINGLE), "hw master");
    cfg.hw_mode <= 1'b0;
    cfg.pdn_adc <= 2'h1;
    for (int s = 0; s < 4; s++) begin
      cfg.speed_sw <= aoc_speed_t'(s);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(DW'(pwr.speed), DW'(s), "speed");
      chk(DW'(pwr.adc_on), 24'h2, "adc pdn");
    end
    cfg.pdn_dev <= 1'b1;
    cfg.pdn_pga <= 2'h2;
    cfg.pdn_pre <= 2'h1;
    cfg.pdn_bias <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(DW'(pwr), DW'({1'b0, 2'h2, 2'h1, 2'h2, 1'b0, SPD_DOUBLE}), "sw pdn");
    give_verdict();
  end
endmodule
